// ### shared/lcd_pkg.sv
`default_nettype none
package lcd_pkg;
   // Core clock and internal oscillator rates
   localparam int CLK_HZ = 25_000_000;
   localparam int OSC_HZ = 32_000;
   localparam int OSC_DIV_CYC = CLK_HZ / OSC_HZ;
   // Frame rates and their length in oscillator ticks
   localparam int FRAME_LO_HZ = 80;
   localparam int FRAME_HI_HZ = 160;
   localparam int FRAME_LO_TICKS = OSC_HZ / FRAME_LO_HZ;
   localparam int FRAME_HI_TICKS = OSC_HZ / FRAME_HI_HZ;
   // Blink rates in tenths of a hertz, half periods in oscillator ticks
   localparam int BLINK_FAST_DHZ = 20;
   localparam int BLINK_MID_DHZ = 10;
   localparam int BLINK_SLOW_DHZ = 5;
   localparam int BLINK_FAST_HALF = OSC_HZ * 10 / (2 * BLINK_FAST_DHZ);
   localparam int BLINK_MID_HALF = OSC_HZ * 10 / (2 * BLINK_MID_DHZ);
   localparam int BLINK_SLOW_HALF = OSC_HZ * 10 / (2 * BLINK_SLOW_DHZ);
   // Counter widths
   localparam int OSC_W = 16;
   localparam int FRAME_W = 9;
   localparam int BLINK_W = 15;
   // Serial bus addressing and commands
   localparam logic [6:0] SLAVE_ADDR = 7'h3E;
   localparam logic [7:0] CMD_DATA = 8'h80;
   localparam logic [7:0] CMD_DRIVE = 8'h82;
   localparam logic [7:0] CMD_SYSTEM = 8'h84;
   localparam logic [7:0] CMD_FRAME = 8'h86;
   localparam logic [7:0] CMD_BLINK = 8'h88;
   // Byte framing counts
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ACK_DONE = 4'h9;
   localparam logic [1:0] IDX_DATA = 2'h2;
   // Display memory
   localparam int RAM_DEPTH = 52;
   localparam int RAM_AW = 6;
   localparam int RAM_DW = 8;
   localparam logic [5:0] LAST_ADDR_QUARTER = 6'h1B;
   localparam logic [5:0] LAST_ADDR_EIGHTH = 6'h33;
   // Setting field positions
   localparam int DUTY_BIT = 1;
   localparam int BIAS_BIT = 0;
   localparam int OSC_EN_BIT = 1;
   localparam int DISP_EN_BIT = 0;
   localparam int FRAME_BIT = 0;
   localparam int BLINK_RATE_HI_BIT = 1;
   localparam int BLINK_RATE_LO_BIT = 0;
   localparam int START_ADDR_MSB = 5;
   // Values after reset
   localparam logic [5:0] START_ADDR_RST = 6'h00;
   localparam logic [1:0] DUTY_BIAS_RST = 2'h0;
   localparam logic [1:0] OSC_DISP_RST = 2'h0;
   localparam logic FRAME_RST = 1'b0;
   localparam logic [1:0] BLINK_RST = 2'h0;
   // Blink selections
   localparam logic [1:0] BLINK_OFF = 2'h0;
   localparam logic [1:0] BLINK_FAST = 2'h1;
   localparam logic [1:0] BLINK_MID = 2'h2;
   localparam logic [1:0] BLINK_SLOW = 2'h3;
   // Serial bus states, Gray coded along idle-addr-rx-tx-idle
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_RX = 2'b11,
      ST_TX = 2'b10
   } bus_state_e;
endpackage
`default_nettype wire

// ### shared/ram_port_if.sv
`default_nettype none
interface ram_port_if;
   logic [lcd_pkg::RAM_AW-1:0] addr;
   logic [lcd_pkg::RAM_DW-1:0] wdata;
   logic [lcd_pkg::RAM_DW-1:0] rdata;
   logic we;
   modport ctrl (output addr, output wdata, output we, input rdata);
   modport mem (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ### logic/disp_ram.sv
`default_nettype none
module disp_ram #(
   parameter int DEPTH = lcd_pkg::RAM_DEPTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Memory port
   ram_port_if.mem port
);
   import lcd_pkg::*;

   logic [RAM_DW-1:0] mem_q [DEPTH];
   logic [RAM_DW-1:0] rdata_q;

   // Write at the addressed location, ignoring addresses past the end
   always_ff @(posedge core_clk) begin
      if (port.we && (int'(port.addr) < DEPTH)) begin
         mem_q[port.addr] <= port.wdata;
      end
   end

   // Registered read data, zero past the end
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else if (int'(port.addr) < DEPTH) begin
         rdata_q <= mem_q[port.addr];
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// ### logic/lcd_ctrl.sv
`default_nettype none
module lcd_ctrl #(
   parameter int OSC_DIV = lcd_pkg::OSC_DIV_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Serial bus pins, data is open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Drive mode
   output logic duty_eighth,
   output logic bias_quarter,
   // Oscillator and display state
   output logic osc_run,
   output logic display_on,
   // Frame timing
   output logic frame_fast,
   output logic frame_tick
);
   import lcd_pkg::*;

   ram_port_if ram ();

   // Pin synchronisers and edge history
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_s;
   logic sda_s;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;

   // Bus engine state
   bus_state_e state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] rx_shift_q;
   logic [7:0] tx_shift_q;
   logic [1:0] byte_idx_q;
   logic [7:0] cmd_q;
   logic sda_oe_q;
   logic sda_o_q;
   logic addr_match;
   logic rx_done;
   logic tx_acked;

   // Settings
   logic [5:0] display_start_address_q;
   logic [1:0] duty_bias_select_q;
   logic [1:0] oscillator_display_enable_q;
   logic frame_rate_select_q;
   logic [1:0] blink_rate_select_q;
   logic [5:0] ptr_last;
   logic [5:0] ptr_next;

   // Timing
   logic [OSC_W-1:0] osc_cnt_q;
   logic osc_tick;
   logic [FRAME_W-1:0] frame_cnt_q;
   logic [FRAME_W-1:0] frame_len;
   logic frame_tick_q;
   logic [BLINK_W-1:0] blink_cnt_q;
   logic [BLINK_W-1:0] blink_half;
   logic blink_phase_q;
   logic display_on_q;
   logic osc_en;
   logic disp_en;

   // Two-stage synchronisers, then one more stage for edges
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   // Bus conditions and clock edges
   assign scl_s = scl_sync_q[1];
   assign sda_s = sda_sync_q[1];
   assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;

   // Address match for the bus engine; byte events seen by the settings logic
   assign addr_match = (rx_shift_q[7:1] == SLAVE_ADDR);
   assign rx_done = (state_q == ST_RX) && scl_fall && (bit_cnt_q == ACK_DONE);
   assign tx_acked = (state_q == ST_TX) && scl_rise && (bit_cnt_q == BYTE_BITS) && !sda_s;

   // Pointer wrap at the last location of the duty mode
   assign ptr_last = duty_bias_select_q[DUTY_BIT] ? LAST_ADDR_EIGHTH : LAST_ADDR_QUARTER;
   assign ptr_next = (display_start_address_q >= ptr_last) ? 6'h00
                     : display_start_address_q + 6'h01;

   // Bus engine: framing, acknowledge and transmit shifting
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         rx_shift_q <= 8'h00;
         tx_shift_q <= 8'h00;
         byte_idx_q <= 2'h0;
         cmd_q <= 8'h00;
         sda_oe_q <= 1'b0;
      end else if (start_det) begin
         // Start or repeated start opens a new address phase
         state_q <= ST_ADDR;
         bit_cnt_q <= 4'h0;
         byte_idx_q <= 2'h0;
         sda_oe_q <= 1'b0;
      end else if (stop_det) begin
         state_q <= ST_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               sda_oe_q <= 1'b0;
            end
            ST_ADDR, ST_RX: begin
               if (scl_rise && (bit_cnt_q < BYTE_BITS)) begin
                  rx_shift_q <= {rx_shift_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_rise && (bit_cnt_q == BYTE_BITS)) begin
                  bit_cnt_q <= ACK_DONE;
               end else if (scl_fall && (bit_cnt_q == BYTE_BITS)) begin
                  if ((state_q == ST_ADDR) && !addr_match) begin
                     state_q <= ST_IDLE;
                  end else begin
                     sda_oe_q <= 1'b1;
                  end
               end else if (scl_fall && (bit_cnt_q == ACK_DONE)) begin
                  sda_oe_q <= 1'b0;
                  bit_cnt_q <= 4'h0;
                  if (state_q == ST_ADDR) begin
                     if (rx_shift_q[0]) begin
                        // Read: first byte goes out MSB first
                        state_q <= ST_TX;
                        tx_shift_q <= ram.rdata;
                        sda_oe_q <= ~ram.rdata[7];
                     end else begin
                        state_q <= ST_RX;
                     end
                  end else begin
                     if (byte_idx_q == 2'h0) begin
                        cmd_q <= rx_shift_q;
                     end
                     if (byte_idx_q != IDX_DATA) begin
                        byte_idx_q <= byte_idx_q + 2'h1;
                     end
                  end
               end
            end
            ST_TX: begin
               if (scl_rise && (bit_cnt_q < ACK_DONE)) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if ((bit_cnt_q == BYTE_BITS) && sda_s) begin
                     state_q <= ST_IDLE;
                  end
               end else if (scl_fall && (bit_cnt_q != 4'h0) && (bit_cnt_q < BYTE_BITS)) begin
                  tx_shift_q <= {tx_shift_q[6:0], 1'b0};
                  sda_oe_q <= ~tx_shift_q[6];
               end else if (scl_fall && (bit_cnt_q == BYTE_BITS)) begin
                  sda_oe_q <= 1'b0;
               end else if (scl_fall && (bit_cnt_q == ACK_DONE)) begin
                  // Master acknowledged: next byte follows
                  bit_cnt_q <= 4'h0;
                  tx_shift_q <= ram.rdata;
                  sda_oe_q <= ~ram.rdata[7];
               end
            end
         endcase
      end
   end

   // Data line only ever pulls low
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         sda_o_q <= 1'b0;
      end else begin
         sda_o_q <= 1'b0;
      end
   end

   // Memory port: data bytes after command 80h land at the pointer
   assign ram.addr = display_start_address_q;
   assign ram.wdata = rx_shift_q;
   assign ram.we = rx_done && (byte_idx_q == IDX_DATA) && (cmd_q == CMD_DATA);

   // Address pointer: load, write advance, read advance
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         display_start_address_q <= START_ADDR_RST;
      end else if (rx_done && (byte_idx_q == 2'h1) && (cmd_q == CMD_DATA)) begin
         display_start_address_q <= rx_shift_q[START_ADDR_MSB:0];
      end else if (ram.we) begin
         display_start_address_q <= ptr_next;
      end else if (tx_acked) begin
         display_start_address_q <= ptr_next;
      end
   end

   // Setting bytes take effect at the end of their acknowledge
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         duty_bias_select_q <= DUTY_BIAS_RST;
         oscillator_display_enable_q <= OSC_DISP_RST;
         frame_rate_select_q <= FRAME_RST;
         blink_rate_select_q <= BLINK_RST;
      end else if (rx_done && (byte_idx_q == 2'h1)) begin
         unique case (cmd_q)
            CMD_DRIVE: begin
               duty_bias_select_q <= rx_shift_q[DUTY_BIT:BIAS_BIT];
            end
            CMD_SYSTEM: begin
               oscillator_display_enable_q <= rx_shift_q[OSC_EN_BIT:DISP_EN_BIT];
            end
            CMD_FRAME: begin
               frame_rate_select_q <= rx_shift_q[FRAME_BIT];
            end
            CMD_BLINK: begin
               blink_rate_select_q <= rx_shift_q[BLINK_RATE_HI_BIT:BLINK_RATE_LO_BIT];
            end
            default: begin
               // Pointer command and unknown codes leave settings alone
               duty_bias_select_q <= duty_bias_select_q;
            end
         endcase
      end
   end

   assign osc_en = oscillator_display_enable_q[OSC_EN_BIT];
   assign disp_en = oscillator_display_enable_q[DISP_EN_BIT];

   // Internal oscillator tick, stopped while disabled
   always_ff @(posedge core_clk) begin
      if (!resetn || !osc_en) begin
         osc_cnt_q <= 16'h0000;
      end else if (osc_cnt_q == OSC_W'(OSC_DIV - 1)) begin
         osc_cnt_q <= 16'h0000;
      end else begin
         osc_cnt_q <= osc_cnt_q + 16'h0001;
      end
   end
   assign osc_tick = osc_en && (osc_cnt_q == OSC_W'(OSC_DIV - 1));

   // Frame length in oscillator ticks
   assign frame_len = frame_rate_select_q ? FRAME_W'(FRAME_HI_TICKS - 1)
                      : FRAME_W'(FRAME_LO_TICKS - 1);

   // Frame divider and one-cycle frame tick
   always_ff @(posedge core_clk) begin
      if (!resetn || !osc_en) begin
         frame_cnt_q <= 9'h000;
         frame_tick_q <= 1'b0;
      end else if (osc_tick && (frame_cnt_q >= frame_len)) begin
         frame_cnt_q <= 9'h000;
         frame_tick_q <= 1'b1;
      end else begin
         frame_cnt_q <= osc_tick ? frame_cnt_q + 9'h001 : frame_cnt_q;
         frame_tick_q <= 1'b0;
      end
   end

   // Blink half period in oscillator ticks
   always_comb begin
      unique case (blink_rate_select_q)
         BLINK_FAST: blink_half = BLINK_W'(BLINK_FAST_HALF - 1);
         BLINK_MID: blink_half = BLINK_W'(BLINK_MID_HALF - 1);
         BLINK_SLOW: blink_half = BLINK_W'(BLINK_SLOW_HALF - 1);
         BLINK_OFF: blink_half = BLINK_W'(BLINK_FAST_HALF - 1);
      endcase
   end

   // Blink phase toggles every half period; shown while off
   always_ff @(posedge core_clk) begin
      if (!resetn || !osc_en || (blink_rate_select_q == BLINK_OFF)) begin
         blink_cnt_q <= 15'h0000;
         blink_phase_q <= 1'b1;
      end else if (osc_tick && (blink_cnt_q >= blink_half)) begin
         blink_cnt_q <= 15'h0000;
         blink_phase_q <= ~blink_phase_q;
      end else if (osc_tick) begin
         blink_cnt_q <= blink_cnt_q + 15'h0001;
      end
   end

   // Display visible only with oscillator, enable and blink phase
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         display_on_q <= 1'b0;
      end else begin
         display_on_q <= osc_en && disp_en && blink_phase_q;
      end
   end

   // Display memory
   disp_ram #(
      .DEPTH(RAM_DEPTH)
   ) u_ram (
      .core_clk(core_clk),
      .resetn(resetn),
      .port(ram.mem)
   );

   // Outputs straight from flip-flops
   assign sda_o = sda_o_q;
   assign sda_oe = sda_oe_q;
   assign duty_eighth = duty_bias_select_q[DUTY_BIT];
   assign bias_quarter = duty_bias_select_q[BIAS_BIT];
   assign osc_run = oscillator_display_enable_q[OSC_EN_BIT];
   assign display_on = display_on_q;
   assign frame_fast = frame_rate_select_q;
   assign frame_tick = frame_tick_q;
endmodule
`default_nettype wire

// ### test/lcd_ctrl_checker.sv
`default_nettype none
module lcd_ctrl_checker #(
   parameter int OSC_DIV = lcd_pkg::OSC_DIV_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // Settings and timing
   input wire logic duty_eighth,
   input wire logic bias_quarter,
   input wire logic osc_run,
   input wire logic display_on,
   input wire logic frame_fast,
   input wire logic frame_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   import lcd_pkg::*;
   logic [31:0] gap_q;
   logic seen_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Cycles since the last frame pulse
   always_ff @(posedge core_clk) begin
      if (!resetn || frame_tick) gap_q <= 32'h1;
      else gap_q <= gap_q + 32'h1;
   end
   // A gap counts only if the oscillator ran and the rate held throughout
   always_ff @(posedge core_clk) begin
      if (!resetn || !osc_run || $changed(frame_fast)) seen_q <= 1'b0;
      else if (frame_tick) seen_q <= 1'b1;
   end
   // Quiet time that must follow each frame pulse
   sequence s_quiet;
      !frame_tick [*8];
   endsequence
   a_reset_values: assert property (
      $rose(resetn) |-> !(duty_eighth | bias_quarter | osc_run | display_on | frame_fast | sda_oe))
      else $error("settings not cleared by reset");
   a_display_osc: assert property (
      display_on |-> osc_run || $past(osc_run))
      else $error("display shown with oscillator stopped");
   a_tick_osc: assert property (
      frame_tick |-> osc_run || $past(osc_run))
      else $error("frame pulse with oscillator stopped");
   a_tick_pulse: assert property (
      frame_tick |=> s_quiet)
      else $error("frame pulse too long");
   // The pulse is launched from the rate of the cycle before it
   a_frame_len: assert property (
      frame_tick && seen_q |-> gap_q == ($past(frame_fast) ? FRAME_HI_TICKS : FRAME_LO_TICKS) * OSC_DIV)
      else $error("frame length wrong");
   a_cfg_scl_low: assert property (
      $changed({duty_eighth, bias_quarter, osc_run, frame_fast}) |-> !$past(scl_i, 2))
      else $error("setting changed outside the acknowledge low phase");
   a_oe_scl_low: assert property (
      $changed(sda_oe) |-> !$past(scl_i, 2))
      else $error("data line changed while clock high");
   a_pull_low_only: assert property (
      sda_oe |-> !sda_o)
      else $error("data line driven high");
endmodule
bind lcd_ctrl lcd_ctrl_checker #(.OSC_DIV(OSC_DIV)) lcd_ctrl_checker_inst (.core_clk(core_clk),
   .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .duty_eighth(duty_eighth), .bias_quarter(bias_quarter), .osc_run(osc_run),
   .display_on(display_on), .frame_fast(frame_fast), .frame_tick(frame_tick));
`default_nettype wire

// ### test/host_master.sv
`default_nettype none
module host_master (
   // Clock
   input wire logic core_clk,
   // Resolved data line
   input wire logic sda_i,
   // Driven pins
   output logic scl,
   output logic sda_pull
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle: clock high, data released
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Quarter of a bus clock period, launched just after the core edge
   task automatic step();
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   // Start or repeated start; extra low time lets the slave release first
   task automatic bus_start();
      sda_pull = 1'b0;
      step();
      step();
      scl = 1'b1;
      step();
      sda_pull = 1'b1;
      step();
      scl = 1'b0;
      step();
   endtask
   // Stop ends a transfer and leaves the bus idle
   task automatic bus_stop();
      sda_pull = 1'b1;
      step();
      scl = 1'b1;
      step();
      sda_pull = 1'b0;
      step();
   endtask
   // One clock: data set while low, sampled mid high
   task automatic bit_io(input logic b, output logic r);
      sda_pull = ~b;
      step();
      scl = 1'b1;
      step();
      r = sda_i;
      step();
      scl = 1'b0;
      step();
   endtask
   // Byte out, highest bit first, then the slave's acknowledge
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, ack);
   endtask
   // Byte in, then acknowledge or refuse
   task automatic recv_byte(output logic [7:0] v, input logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(nack, r);
   endtask
endmodule
`default_nettype wire

// ### test/test_lcd_ctrl.sv
`default_nettype none
module test_lcd_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import lcd_pkg::*;
   localparam int DIV = 4;
   logic core_clk = 1'b0;
   logic resetn, scl, sda_pull, sda_o, sda_oe, duty_eighth, bias_quarter;
   logic osc_run, display_on, frame_fast, frame_tick;
   logic w_duty, w_bias, w_osc, w_disp, w_frame;
   logic [15:0] exp_q [$];
   logic [15:0] obs_q [$];
   logic [7:0] undef [3] = '{8'h81, 8'h8C, 8'h00};
   int fails = 0;
   int total_checks = 0;
   int seed = 13;
   wire sda_line = ~(sda_oe | sda_pull);
   lcd_ctrl #(.OSC_DIV(DIV)) lcd_ctrl_inst (.core_clk(core_clk), .resetn(resetn), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .duty_eighth(duty_eighth),
      .bias_quarter(bias_quarter), .osc_run(osc_run), .display_on(display_on),
      .frame_fast(frame_fast), .frame_tick(frame_tick));
   host_master host_master_inst (.core_clk(core_clk), .sda_i(sda_line), .scl(scl), .sda_pull(sda_pull));
   // 25 MHz core clock
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      total_checks++;
      if (seen !== want) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      if (exp_q.size() != 0) fails++;
      if (fails == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Pairs each observed result with the oldest expectation
   initial begin
      forever begin
         @(negedge core_clk);
         while (obs_q.size() > 0) check(obs_q.pop_front(), exp_q.pop_front());
      end
   end
   task automatic note(input logic [15:0] want, input logic [15:0] seen);
      exp_q.push_back(want);
      obs_q.push_back(seen);
   endtask
   task automatic snap();
      note({11'h0, w_duty, w_bias, w_osc, w_disp, w_frame},
         {9'h0, sda_o, sda_oe, duty_eighth, bias_quarter, osc_run, display_on, frame_fast});
   endtask
   task automatic xfer(input logic [7:0] v, input logic nack);
      logic a;
      host_master_inst.send_byte(v, a);
      note({15'h0, nack}, {15'h0, a});
   endtask
   task automatic setting(input logic [7:0] cmd, input logic [7:0] val);
      host_master_inst.bus_start();
      xfer({SLAVE_ADDR, 1'b0}, 1'b0);
      xfer(cmd, 1'b0);
      xfer(val, 1'b0);
      host_master_inst.bus_stop();
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   // Counts core edges while display_on (sel high) or frame_tick holds a level, bounded
   task automatic run_len(input logic sel, input logic lvl, output logic [15:0] n);
      n = 16'h0;
      while ((sel ? display_on : frame_tick) === lvl && n < 16'hFFFF) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask
   // Main sequence
   initial begin
      logic [7:0] r;
      logic [7:0] v;
      logic [5:0] last;
      logic [7:0] d [3];
      logic [15:0] n;
      resetn = 1'b0;
      {w_duty, w_bias, w_osc, w_disp, w_frame} = 5'h0;
      repeat (3) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      snap();
      for (int i = 0; i < 4; i++) begin
         r = 8'($random(seed));
         setting(CMD_DRIVE, {r[7:2], i[1:0]});
         {w_duty, w_bias} = i[1:0];
         snap();
         setting(CMD_SYSTEM, {r[7:2], i[1:0]});
         w_osc = i[1];
         w_disp = i[1] & i[0];
         snap();
      end
      foreach (undef[k]) begin
         setting(undef[k], 8'hFF);
         snap();
      end
      for (int f = 1; f >= 0; f--) begin
         r = 8'($random(seed));
         setting(CMD_FRAME, {r[7:1], f[0]});
         w_frame = f[0];
         snap();
         run_len(1'b0, 1'b0, n);
         run_len(1'b0, 1'b1, n);
         run_len(1'b0, 1'b0, n);
         note(16'((f[0] ? FRAME_HI_TICKS : FRAME_LO_TICKS) * DIV - 1), n);
      end
      setting(CMD_BLINK, {6'h0, BLINK_FAST});
      run_len(1'b1, 1'b1, n);
      run_len(1'b1, 1'b0, n);
      note(16'(BLINK_FAST_HALF * DIV), n);
      for (int b = 3; b >= 0; b--) begin
         r = 8'($random(seed));
         setting(CMD_BLINK, {r[7:2], b[1:0]});
         snap();
      end
      for (int u = 0; u < 2; u++) begin
         last = u[0] ? LAST_ADDR_EIGHTH : LAST_ADDR_QUARTER;
         setting(CMD_DRIVE, {6'h0, u[0], 1'b0});
         {w_duty, w_bias} = {u[0], 1'b0};
         r = 8'($random(seed));
         host_master_inst.bus_start();
         xfer({SLAVE_ADDR, 1'b0}, 1'b0);
         xfer(CMD_DATA, 1'b0);
         xfer({r[7:6], last - 6'h1}, 1'b0);
         for (int k = 0; k < 3; k++) begin
            d[k] = 8'($random(seed));
            xfer(d[k], 1'b0);
         end
         host_master_inst.bus_stop();
         host_master_inst.bus_start();
         xfer({SLAVE_ADDR, 1'b0}, 1'b0);
         xfer(CMD_DATA, 1'b0);
         xfer({2'h0, last - 6'h1}, 1'b0);
         host_master_inst.bus_start();
         xfer({SLAVE_ADDR, 1'b1}, 1'b0);
         for (int k = 0; k < 3; k++) begin
            host_master_inst.recv_byte(v, k == 2);
            note({8'h0, d[k]}, {8'h0, v});
         end
         host_master_inst.bus_stop();
         // Refused byte leaves the pointer where it was
         host_master_inst.bus_start();
         xfer({SLAVE_ADDR, 1'b1}, 1'b0);
         host_master_inst.recv_byte(v, 1'b1);
         note({8'h0, d[2]}, {8'h0, v});
         host_master_inst.bus_stop();
      end
      snap();
      host_master_inst.bus_start();
      xfer({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1);
      host_master_inst.bus_stop();
      repeat (10) @(posedge core_clk);
      wrap_up();
   end
   // Whole run needs about 80000 cycles; cut off with margin below 100000
   initial begin
      #(95000 * 40);
      fails++;
      wrap_up();
   end
endmodule
`default_nettype wire
